//--- verilog/psr_responder.v
// Two-wire command responder with checksummed frames and the status byte.
// How it works
// R1: Bits MSB first, words high byte first.
// R2: Command 21h gives 64-byte zero-sum sensor frame.
// R3: Telemetry scaled; negative rail reported as magnitude.
// R4: Part number space padded, no zero terminator.
// R5: Serial number is 32-bit, last nine digits.
// R6: Command 44h gives 22-byte firmware date frame.
// R7: Command 45h returns bus address and checksum.
// R8: Command 55h reads or writes status byte.
// R9: Command 90h returns seven rail voltages.
// R10: Command 99h returns main and input currents.
// R11: Command 91h returns auxiliary currents.
// R12: Command 92h returns two rail temperatures.
// R13: Status bits 1:0 mirror inhibit, enable pins.
// R14: Bit 4 gives software control over pins.
// R15: Bits 3:2 active low, default zero.
// R16: Any fault clears status bit 6; here only fault_i clears it, an over-temperature fault leaves it set.
// R17: Over-temperature fault clears status bit 5.
// R18: Override keeps outputs on through non-recoverable events.
// R19: Event messages still raised under override.
// R20: Requestor sends identical status write three times.
// R21: Override arms after third write checksum.
// R22: Status read after arming shows 82h.
// R23: Requestor uses address byte with R/W LSB.
// R24: Address 01000 plus inverted geographic pins.
// R25: Checksum makes covered bytes sum to zero.
// R26: Requestor clocks bus; device answers reads only.
// R27: Bad checksum requests are ignored entirely.
// R28: Non-matching request restarts override arming count.
`timescale 1ns/1ps
`include "psr_consts.vh"
module psr_responder
#(
   parameter [159:0] PART_NUMBER = "PSU-MODULE          ",
   parameter [31:0]  SERIAL_NUM  = 32'h00000000,
   parameter [159:0] FW_DATE     = "JAN 01 00:00:00 2000"
)
(
   input  wire         clk_i,
   input  wire         rst_b_i,
   input  wire         scl_i,
   input  wire         sda_i,
   output reg          sda_o,
   output reg          sda_oe_b_o,
   input  wire         geo_addr_bit1_n_i,
   input  wire         geo_addr_bit0_n_i,
   input  wire         pin_inhibit_state_n_i,
   input  wire         pin_enable_state_n_i,
   input  wire         fault_i,
   input  wire         overtemp_fault_i,
   input  wire         nonrec_event_i,
   input  wire [15:0]  board_temp_i,
   input  wire [223:0] tele_i,
   input  wire [7:0]   vin_current_i,
   input  wire [111:0] volts_i,
   input  wire [63:0]  main_amps_i,
   input  wire [47:0]  aux_amps_i,
   input  wire [31:0]  rail_temp_i,
   output reg          rails_on_o,
   output reg          event_msg_o,
   output reg  [7:0]   status_o
);
   localparam [2:0] ST_IDLE  = 3'h0;
   localparam [2:0] ST_ADDR  = 3'h1;
   localparam [2:0] ST_AACK  = 3'h2;
   localparam [2:0] ST_WBYTE = 3'h3;
   localparam [2:0] ST_WACK  = 3'h4;
   localparam [2:0] ST_RBYTE = 3'h5;
   localparam [2:0] ST_RACK  = 3'h6;

   wire [5:0] sync_w;
   wire       scl_s;
   wire       sda_s;
   wire       ga1_n_s;
   wire       ga0_n_s;
   wire       inh_n_s;
   wire       en_n_s;
   wire [7:0] rom_byte;
   wire [6:0] rom_len;
   wire [6:0] my_addr;
   wire       start_det;
   wire       stop_det;
   wire       scl_rise;
   wire       scl_fall;
   wire [7:0] rx_byte;
   wire [7:0] status_byte;
   wire       req_done;
   wire       req_ok;

   reg [2:0]  state_r;
   reg [2:0]  bit_cnt_r;
   reg [7:0]  shift_r;
   reg        ack_on_r;
   reg        scl_d_r;
   reg        sda_d_r;
   reg        wr_act_r;
   reg [2:0]  rx_cnt_r;
   reg [7:0]  rx_sum_r;
   reg [7:0]  cmd_rx_r;
   reg [7:0]  data_rx_r;
   reg [7:0]  rsp_cmd_r;
   reg [6:0]  tx_idx_r;
   reg [7:0]  tx_sum_r;
   reg [7:0]  tx_nxt;
   reg [4:0]  ctl_r;
   reg        override_r;
   reg [1:0]  arm_cnt_r;
   reg [7:0]  arm_data_r;
   reg        nonrec_d_r;
   reg        eff_en_n;
   reg        eff_inh_n;

   psr_sync #(.WIDTH(6)) u_sync
   (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .d_i     ({scl_i, sda_i, geo_addr_bit1_n_i, geo_addr_bit0_n_i,
                 pin_inhibit_state_n_i, pin_enable_state_n_i}),
      .q_o     (sync_w)
   );

   assign scl_s   = sync_w[5];
   assign sda_s   = sync_w[4];
   assign ga1_n_s = sync_w[3];
   assign ga0_n_s = sync_w[2];
   assign inh_n_s = sync_w[1];
   assign en_n_s  = sync_w[0];

   assign my_addr = {`PSR_ADDR_PREFIX, ~ga1_n_s, ~ga0_n_s}; // [R24]

   // The read-only low bits follow the pins live.
   assign status_byte = {override_r, ctl_r, inh_n_s, en_n_s}; // [R13] [R22]

   psr_resp_rom #(.PART_NUMBER(PART_NUMBER), .SERIAL_NUM(SERIAL_NUM),
                  .FW_DATE(FW_DATE)) u_rom
   (
      .cmd_i         (rsp_cmd_r),
      .idx_i         (tx_idx_r),
      .status_i      (status_byte),
      .bus_addr_i    ({1'b0, my_addr}),
      .board_temp_i  (board_temp_i),
      .tele_i        (tele_i),
      .vin_current_i (vin_current_i),
      .volts_i       (volts_i),
      .main_amps_i   (main_amps_i),
      .aux_amps_i    (aux_amps_i),
      .rail_temp_i   (rail_temp_i),
      .byte_o        (rom_byte),
      .len_o         (rom_len)
   );

   assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
   assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
   assign scl_rise  = scl_s & ~scl_d_r;
   assign scl_fall  = ~scl_s & scl_d_r;
   assign rx_byte   = {shift_r[6:0], sda_s};

   // Last frame byte is the two's complement of the running sum.
   always @*
   begin
      if (tx_idx_r >= rom_len)
         tx_nxt = 8'hff;
      else if (tx_idx_r == rom_len - 7'h01)
         tx_nxt = 8'h00 - tx_sum_r; // [R25] [R2]
      else
         tx_nxt = rom_byte;
   end

   assign req_done = (start_det | stop_det) & wr_act_r;
   assign req_ok   = (rx_sum_r == 8'h00) &&
                     ((rx_cnt_r == 3'h2) ||
                      (rx_cnt_r == 3'h3 && cmd_rx_r == `PSR_CMD_STATUS)); // [R27] [R25]

   always @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         state_r    <= ST_IDLE;
         bit_cnt_r  <= 3'h0;
         shift_r    <= 8'h00;
         ack_on_r   <= 1'b0;
         scl_d_r    <= 1'b1;
         sda_d_r    <= 1'b1;
         sda_o      <= 1'b0;
         sda_oe_b_o <= 1'b1;
         wr_act_r   <= 1'b0;
         rx_cnt_r   <= 3'h0;
         rx_sum_r   <= 8'h00;
         cmd_rx_r   <= 8'h00;
         data_rx_r  <= 8'h00;
         tx_idx_r   <= 7'h00;
         tx_sum_r   <= 8'h00;
      end
      else
      begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
         if (req_done)
            wr_act_r <= 1'b0;
         if (start_det)
         begin
            state_r    <= ST_ADDR;
            bit_cnt_r  <= 3'h0;
            ack_on_r   <= 1'b0;
            sda_oe_b_o <= 1'b1;
         end
         else if (stop_det)
         begin
            state_r    <= ST_IDLE;
            sda_oe_b_o <= 1'b1;
         end
         else
         begin
            case (state_r)
               ST_ADDR, ST_WBYTE:
               begin
                  if (scl_rise)
                  begin
                     shift_r   <= rx_byte;
                     bit_cnt_r <= bit_cnt_r + 3'h1;
                     if (bit_cnt_r == 3'h7 && state_r == ST_ADDR)
                     begin
                        if (rx_byte[7:1] == my_addr)
                        begin
                           state_r  <= ST_AACK;
                           tx_idx_r <= 7'h00;
                           tx_sum_r <= 8'h00;
                           if (!rx_byte[0])
                           begin
                              wr_act_r <= 1'b1;
                              rx_cnt_r <= 3'h0;
                              rx_sum_r <= 8'h00;
                           end
                        end
                        else
                           state_r <= ST_IDLE;
                     end
                     else if (bit_cnt_r == 3'h7)
                     begin
                        state_r  <= ST_WACK;
                        rx_sum_r <= rx_sum_r + rx_byte;
                        if (rx_cnt_r != 3'h7)
                           rx_cnt_r <= rx_cnt_r + 3'h1;
                        if (rx_cnt_r == 3'h0)
                           cmd_rx_r <= rx_byte;
                        if (rx_cnt_r == 3'h1)
                           data_rx_r <= rx_byte;
                     end
                  end
               end
               ST_AACK, ST_WACK:
               begin
                  if (scl_fall && !ack_on_r)
                  begin
                     ack_on_r   <= 1'b1;
                     sda_oe_b_o <= 1'b0;
                  end
                  else if (scl_fall)
                  begin
                     ack_on_r  <= 1'b0;
                     bit_cnt_r <= 3'h0;
                     if (state_r == ST_AACK && shift_r[0])
                     begin
                        state_r    <= ST_RBYTE;
                        shift_r    <= {tx_nxt[6:0], 1'b0};
                        sda_oe_b_o <= tx_nxt[7]; // [R1] [R26]
                        tx_sum_r   <= tx_sum_r + tx_nxt;
                        tx_idx_r   <= tx_idx_r + 7'h01;
                     end
                     else
                     begin
                        state_r    <= ST_WBYTE;
                        sda_oe_b_o <= 1'b1;
                     end
                  end
               end
               ST_RBYTE:
               begin
                  if (scl_fall)
                  begin
                     bit_cnt_r <= bit_cnt_r + 3'h1;
                     if (bit_cnt_r == 3'h7)
                     begin
                        state_r    <= ST_RACK;
                        sda_oe_b_o <= 1'b1;
                     end
                     else
                     begin
                        sda_oe_b_o <= shift_r[7]; // [R1]
                        shift_r    <= {shift_r[6:0], 1'b0};
                     end
                  end
               end
               ST_RACK:
               begin
                  if (scl_rise)
                  begin
                     ack_on_r <= ~sda_s;
                     if (sda_s)
                        state_r <= ST_IDLE;
                  end
                  else if (scl_fall && ack_on_r)
                  begin
                     ack_on_r   <= 1'b0;
                     bit_cnt_r  <= 3'h0;
                     state_r    <= ST_RBYTE;
                     shift_r    <= {tx_nxt[6:0], 1'b0};
                     sda_oe_b_o <= tx_nxt[7]; // [R1]
                     tx_sum_r   <= tx_sum_r + tx_nxt;
                     if (tx_idx_r != 7'h7f)
                        tx_idx_r <= tx_idx_r + 7'h01;
                  end
               end
               default:
               begin
                  state_r <= ST_IDLE;
               end
            endcase
         end
      end
   end

   // Request evaluation, status writes and override arming.
   always @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rsp_cmd_r  <= 8'h00;
         ctl_r      <= `PSR_STATUS_RESET; // [R15]
         override_r <= 1'b0;
         arm_cnt_r  <= 2'h0;
         arm_data_r <= 8'h00;
      end
      else
      begin
         if (req_done && req_ok)
         begin
            rsp_cmd_r <= cmd_rx_r;
            if (rx_cnt_r == 3'h3)
            begin
               ctl_r <= data_rx_r[6:2]; // [R8] [R14] [R15]
               if (!data_rx_r[`PSR_ST_OVERRIDE])
                  override_r <= 1'b0;
               if (arm_cnt_r != 2'h0 && data_rx_r == arm_data_r)
               begin
                  if (arm_cnt_r != `PSR_ARM_WRITES)
                     arm_cnt_r <= arm_cnt_r + 2'h1;
                  if (arm_cnt_r == `PSR_ARM_WRITES - 2'h1 &&
                      data_rx_r[`PSR_ST_OVERRIDE])
                     override_r <= 1'b1; // [R21] [R20]
               end
               else
               begin
                  arm_cnt_r  <= 2'h1; // [R28]
                  arm_data_r <= data_rx_r;
               end
            end
            else
               arm_cnt_r <= 2'h0; // [R28]
         end
         if (fault_i)
            ctl_r[`PSR_ST_FAIL - 2] <= 1'b0; // [R16]
         if (overtemp_fault_i)
            ctl_r[`PSR_ST_OT - 2] <= 1'b0; // [R17]
      end
   end

   // Effective controls: software bits replace the pins when selected.
   always @*
   begin
      if (ctl_r[`PSR_ST_SW_SEL - 2])
      begin
         eff_en_n  = ctl_r[`PSR_ST_SOFT_ENABLE_N_N - 2]; // [R14]
         eff_inh_n = ctl_r[`PSR_ST_SOFT_INHIBIT_N_N - 2];
      end
      else
      begin
         eff_en_n  = en_n_s;
         eff_inh_n = inh_n_s;
      end
   end

   always @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rails_on_o  <= 1'b0;
         event_msg_o <= 1'b0;
         nonrec_d_r  <= 1'b0;
         status_o    <= 8'h00;
      end
      else
      begin
         nonrec_d_r  <= nonrec_event_i;
         event_msg_o <= nonrec_event_i & ~nonrec_d_r; // [R19]
         rails_on_o  <= ~eff_en_n & eff_inh_n &
                        ~(nonrec_event_i & ~override_r); // [R18]
         status_o    <= status_byte;
      end
   end
endmodule // psr_responder

//--- verilog/psr_consts.vh
// Constants for the power-supply sensor command responder.
`ifndef PSR_CONSTS_VH
`define PSR_CONSTS_VH

`define PSR_ADDR_PREFIX   5'h08
`define PSR_CMD_SENSOR    8'h21
`define PSR_CMD_FW_DATE   8'h44
`define PSR_CMD_HW_ADDR   8'h45
`define PSR_CMD_STATUS    8'h55
`define PSR_CMD_VOLTS     8'h90
`define PSR_CMD_AUX_AMPS  8'h91
`define PSR_CMD_TEMPS     8'h92
`define PSR_CMD_MAIN_AMPS 8'h99

`define PSR_LEN_SENSOR    7'h40
`define PSR_LEN_FW_DATE   7'h16
`define PSR_LEN_HW_ADDR   7'h03
`define PSR_LEN_STATUS    7'h03
`define PSR_LEN_VOLTS     7'h10
`define PSR_LEN_AUX_AMPS  7'h08
`define PSR_LEN_TEMPS     7'h06
`define PSR_LEN_MAIN_AMPS 7'h0a

`define PSR_ST_OVERRIDE   7
`define PSR_ST_FAIL       6
`define PSR_ST_OT         5
`define PSR_ST_SW_SEL     4
`define PSR_ST_SOFT_INHIBIT_N_N   3
`define PSR_ST_SOFT_ENABLE_N_N    2
`define PSR_STATUS_RESET  5'h00
`define PSR_ARM_WRITES    2'h3

`endif

//--- verilog/psr_sync.v
// Two-flip-flop synchroniser for a group of pin inputs.
`timescale 1ns/1ps
module psr_sync
#(
   parameter WIDTH = 1
)
(
   input  wire             clk_i,
   input  wire             rst_b_i,
   input  wire [WIDTH-1:0] d_i,
   output reg  [WIDTH-1:0] q_o
);
   reg [WIDTH-1:0] meta_r;

   always @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         meta_r <= {WIDTH{1'b1}};
         q_o    <= {WIDTH{1'b1}};
      end
      else
      begin
         meta_r <= d_i;
         q_o    <= meta_r;
      end
   end
endmodule // psr_sync

//--- verilog/psr_resp_rom.v
// Response byte source: picks one frame byte by command and index.
`timescale 1ns/1ps
`include "psr_consts.vh"
module psr_resp_rom
#(
   parameter [159:0] PART_NUMBER = "PSU-MODULE          ",
   parameter [31:0]  SERIAL_NUM  = 32'h00000000,
   parameter [15:0]  FACTORY_USE = 16'h0000,
   parameter [15:0]  HW_REV      = "A0",
   parameter [15:0]  FW_REV      = "10",
   parameter [159:0] FW_DATE     = "JAN 01 00:00:00 2000"
)
(
   input  wire [7:0]   cmd_i,
   input  wire [6:0]   idx_i,
   input  wire [7:0]   status_i,
   input  wire [7:0]   bus_addr_i,
   input  wire [15:0]  board_temp_i,
   input  wire [223:0] tele_i,
   input  wire [7:0]   vin_current_i,
   input  wire [111:0] volts_i,
   input  wire [63:0]  main_amps_i,
   input  wire [47:0]  aux_amps_i,
   input  wire [31:0]  rail_temp_i,
   output reg  [7:0]   byte_o,
   output reg  [6:0]   len_o
);
   reg [6:0]  k;
   reg [15:0] w;

   always @*
   begin
      k      = 7'h00;
      w      = 16'h0000;
      byte_o = 8'hff;
      len_o  = 7'h00;
      if (cmd_i == `PSR_CMD_SENSOR)
      begin
         len_o = `PSR_LEN_SENSOR;
         if (idx_i == 7'h01)
            byte_o = status_i;
         else if (idx_i < 7'h04)
         begin
            byte_o = idx_i[0] ? board_temp_i[7:0] : board_temp_i[15:8]; // [R1]
         end
         else if (idx_i < 7'h20)
         begin
            k = (idx_i - 7'h04) >> 1;
            w = tele_i[k*16 +: 16];
            if ((k == 7'h05 || k == 7'h0b) && w[15])
               w = 16'h0000 - w; // [R3]
            byte_o = idx_i[0] ? w[7:0] : w[15:8]; // [R1]
         end
         else if (idx_i < 7'h34)
         begin
            k = 7'h33 - idx_i;
            byte_o = PART_NUMBER[k*8 +: 8]; // [R4]
         end
         else if (idx_i < 7'h38)
         begin
            k = 7'h37 - idx_i;
            byte_o = SERIAL_NUM[k*8 +: 8]; // [R5]
         end
         else if (idx_i < 7'h3a)
            byte_o = idx_i[0] ? FACTORY_USE[7:0] : FACTORY_USE[15:8];
         else if (idx_i < 7'h3c)
            byte_o = idx_i[0] ? HW_REV[7:0] : HW_REV[15:8];
         else if (idx_i < 7'h3e)
            byte_o = idx_i[0] ? FW_REV[7:0] : FW_REV[15:8];
         else
            byte_o = vin_current_i; // [R2]
      end
      else if (cmd_i == `PSR_CMD_FW_DATE)
      begin
         len_o = `PSR_LEN_FW_DATE;
         k = 7'h14 - idx_i;
         if (idx_i != 7'h00 && idx_i < 7'h15)
            byte_o = FW_DATE[k*8 +: 8]; // [R6]
      end
      else if (cmd_i == `PSR_CMD_HW_ADDR)
      begin
         len_o  = `PSR_LEN_HW_ADDR;
         byte_o = bus_addr_i; // [R7]
      end
      else if (cmd_i == `PSR_CMD_STATUS)
      begin
         len_o  = `PSR_LEN_STATUS;
         byte_o = status_i; // [R8]
      end
      else if (cmd_i == `PSR_CMD_VOLTS || cmd_i == `PSR_CMD_MAIN_AMPS ||
               cmd_i == `PSR_CMD_AUX_AMPS || cmd_i == `PSR_CMD_TEMPS)
      begin
         k = (idx_i - 7'h01) >> 1;
         if (cmd_i == `PSR_CMD_VOLTS)
         begin
            len_o = `PSR_LEN_VOLTS;
            w = volts_i[k*16 +: 16];
            if (k == 7'h05)
               w = 16'h0000 - w; // [R9]
         end
         else if (cmd_i == `PSR_CMD_MAIN_AMPS)
         begin
            len_o = `PSR_LEN_MAIN_AMPS;
            w = main_amps_i[k*16 +: 16]; // [R10]
         end
         else if (cmd_i == `PSR_CMD_AUX_AMPS)
         begin
            len_o = `PSR_LEN_AUX_AMPS;
            w = aux_amps_i[k*16 +: 16];
            if (k == 7'h02)
               w = 16'h0000 - w; // [R11]
         end
         else
         begin
            len_o = `PSR_LEN_TEMPS;
            w = rail_temp_i[k*16 +: 16]; // [R12]
         end
         byte_o = idx_i[0] ? w[15:8] : w[7:0]; // [R1]
      end
      if (idx_i == 7'h00)
         byte_o = cmd_i;
   end
endmodule // psr_resp_rom

//--- verif/psr_monitor.sv
// Checker for the responder's pin-level and status behaviour.
`timescale 1ns/1ps
module psr_monitor (
   input wire       clk_i,
   input wire       rst_b_i,
   input wire       sda_o,
   input wire       scl_i,
   input wire       sda_oe_b_o,
   input wire       pin_inhibit_state_n_i,
   input wire       pin_enable_state_n_i,
   input wire       fault_i,
   input wire       overtemp_fault_i,
   input wire       nonrec_event_i,
   input wire       rails_on_o,
   input wire       event_msg_o,
   input wire [7:0] status_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);
   wire [1:0] pins_n    = {pin_inhibit_state_n_i, pin_enable_state_n_i};
   wire       ctl_on    = status_o[4] ? (status_o[3] & ~status_o[2]) : (pins_n == 2'b10);
   wire       rails_exp = ctl_on & ~(nonrec_event_i & ~status_o[7]);
   a_sda_low_only: assert property (sda_o == 1'b0 && (!$changed(sda_oe_b_o) || !scl_i))
      else $error("data pin misdriven");
   a_pins_mirror: assert property ($stable(pins_n) [*8] |-> status_o[1:0] == pins_n)
      else $error("read-only bits differ from pins");
   a_rails_control: assert property (
      $stable({pins_n, nonrec_event_i, status_o}) [*8] |-> rails_on_o == rails_exp)
      else $error("output enable wrong");
   a_status_reset: assert property ($rose(rst_b_i) |-> status_o[7:2] == 6'h00)
      else $error("status not cleared by reset");
   a_fail_clear: assert property (fault_i [*2] |=> !status_o[6])
      else $error("fault did not clear bit 6");
   a_ot_clear: assert property (overtemp_fault_i [*2] |=> !status_o[5])
      else $error("overtemp did not clear bit 5");
   a_event_raise: assert property ($rose(nonrec_event_i) |-> ##[0:3] event_msg_o)
      else $error("no event message");
   a_event_pulse: assert property (event_msg_o |=> !event_msg_o)
      else $error("event message too long");
   a_event_cause: assert property ($rose(event_msg_o) |-> nonrec_event_i ||
      $past(nonrec_event_i) || $past(nonrec_event_i, 2))
      else $error("event message without cause");
endmodule // psr_monitor

bind psr_responder psr_monitor i_psr_monitor (.clk_i, .rst_b_i, .sda_o, .pin_inhibit_state_n_i,
   .pin_enable_state_n_i, .fault_i, .overtemp_fault_i, .nonrec_event_i, .rails_on_o,
   .event_msg_o, .status_o, .scl_i, .sda_oe_b_o);

//--- verif/psr_master.sv
// Bus requestor model that clocks the two-wire port.
`timescale 1ns/1ps
module psr_master (
   input  wire clk_i,
   input  wire sda_i,
   output reg  scl_o,
   output reg  sda_oe_b_o
);
   initial
   begin
      scl_o      = 1'b1;
      sda_oe_b_o = 1'b1;
   end
   task qtr;
      repeat (4) @(negedge clk_i);
   endtask
   task bit_io(input b, output r);
   begin
      sda_oe_b_o = b;
      qtr;
      scl_o = 1'b1;
      qtr;
      r = sda_i;
      qtr;
      scl_o = 1'b0;
      qtr;
   end
   endtask
   task start;
   begin
      sda_oe_b_o = 1'b1;
      scl_o = 1'b1;
      qtr;
      sda_oe_b_o = 1'b0;
      qtr;
      scl_o = 1'b0;
      qtr;
   end
   endtask
   task stop;
   begin
      sda_oe_b_o = 1'b0;
      qtr;
      scl_o = 1'b1;
      qtr;
      sda_oe_b_o = 1'b1;
      qtr;
   end
   endtask
   task wr(input [7:0] d, output ack);
      integer i;
      reg     r;
   begin
      for (i = 7; i >= 0; i = i - 1)
         bit_io(d[i], r);
      bit_io(1'b1, ack);
   end
   endtask
   task rd(input nack, output [7:0] d);
      integer i;
      reg     r;
   begin
      for (i = 7; i >= 0; i = i - 1)
      begin
         bit_io(1'b1, r);
         d[i] = r;
      end
      bit_io(nack, r);
   end
   endtask
endmodule // psr_master

//--- verif/psr_responder_tb.sv
// Self-checking bench for the two-wire command responder.
`timescale 1ns/1ps
module psr_responder_tb;
   localparam [159:0] PN   = "TEST-PSU            ";
   localparam [31:0]  SN   = 32'h075bcd15;
   localparam [159:0] DATE = "MAR 03 12:00:00 2021";
   localparam [55:0]  CMDS = 56'h21_44_45_90_91_92_99;
   reg          clk_i, rst_b_i, ga1_n, ga0_n, inh_n, en_n, fault, ot, nrec, a;
   reg  [15:0]  btemp = 16'h0fa0;
   reg  [223:0] tele  = {7{32'hc123_0456}};
   reg  [7:0]   vin   = 8'h5a;
   reg  [111:0] volts = {16'h0af0, 16'hfb50, {5{16'h04d2}}};
   reg  [63:0]  mamps = 64'h1388_0bb8_07d0_03e8;
   reg  [47:0]  aamps = {16'hfc18, 16'h0064, 16'h0ce4};
   reg  [31:0]  rtemp = {16'h0146, 16'h013b};
   reg  [7:0]   f [0:63];
   reg  [7:0]   sexp, b8;
   integer      n, i, mismatches = 0, n_checks = 0;
   wire         dev_oe_b, m_oe_b, scl, rails_on, ev_msg;
   wire [7:0]   status;
   wire         sda  = dev_oe_b & m_oe_b;
   wire [6:0]   addr = {5'h08, ~ga1_n, ~ga0_n};
   wire [239:0] w21  = {tele[223:192], -tele[191:176], tele[175:96], -tele[95:80], tele[79:0],
                        btemp};
   wire [111:0] w90  = {volts[111:96], -volts[95:80], volts[79:0]};
   wire [47:0]  w91  = {-aamps[47:32], aamps[31:0]};

   psr_responder #(.PART_NUMBER(PN), .SERIAL_NUM(SN), .FW_DATE(DATE)) i_psr_responder (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .scl_i(scl), .sda_i(sda), .sda_o(),
      .sda_oe_b_o(dev_oe_b), .geo_addr_bit1_n_i(ga1_n), .geo_addr_bit0_n_i(ga0_n),
      .pin_inhibit_state_n_i(inh_n), .pin_enable_state_n_i(en_n), .fault_i(fault),
      .overtemp_fault_i(ot), .nonrec_event_i(nrec), .board_temp_i(btemp), .tele_i(tele),
      .vin_current_i(vin), .volts_i(volts), .main_amps_i(mamps), .aux_amps_i(aamps),
      .rail_temp_i(rtemp), .rails_on_o(rails_on), .event_msg_o(ev_msg), .status_o(status));
   psr_master i_psr_master (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .sda_oe_b_o(m_oe_b));

   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   task wt(input integer c);
      repeat (c) @(negedge clk_i);
   endtask
   task check(input [7:0] got, input [7:0] exp);
   begin
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
         mismatches = mismatches + 1;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask
   task report_and_stop;
   begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end
   endtask
   task build(input [7:0] c);
      integer     k, nw, b;
      reg [239:0] w;
      reg [7:0]   s;
   begin
      case (c)
         8'h21: n = 64;
         8'h44: n = 22;
         8'h90: n = 16;
         8'h91: n = 8;
         8'h92: n = 6;
         8'h99: n = 10;
         default: n = 3;
      endcase
      w = (c == 8'h21) ? w21 : (c == 8'h90) ? w90 : (c == 8'h91) ? w91 :
          (c == 8'h92) ? rtemp : mamps;
      nw = (c == 8'h21) ? 15 : (c[7:4] == 4'h9) ? (n - 2) / 2 : 0;
      b = (c == 8'h21) ? 2 : 1;
      f[0] = c;
      f[1] = (c == 8'h45) ? {1'b0, addr} : {sexp[7:2], inh_n, en_n};
      for (k = 0; k < nw; k = k + 1)
         {f[b + 2 * k], f[b + 2 * k + 1]} = w[16 * k +: 16];
      for (k = 0; k < 20; k = k + 1)
      begin
         if (c == 8'h21)
            f[32 + k] = PN[159 - 8 * k -: 8];
         if (c == 8'h44)
            f[1 + k] = DATE[159 - 8 * k -: 8];
      end
      if (c == 8'h21)
         {f[52], f[53], f[54], f[55], f[56], f[57], f[58], f[59], f[60], f[61], f[62]} =
            {SN, 16'h0000, "A0", "10", vin};
      s = 8'h00;
      for (k = 0; k < n - 1; k = k + 1)
         s = s + f[k];
      f[n - 1] = 8'h00 - s;
   end
   endtask
   task req(input [7:0] c, input [7:0] d, input nd, input [7:0] bad);
   begin
      i_psr_master.start;
      i_psr_master.wr({addr, 1'b0}, a);
      check({7'h0, a}, 8'h00);
      i_psr_master.wr(c, a);
      if (nd)
         i_psr_master.wr(d, a);
      i_psr_master.wr(8'h00 - c - (nd ? d : 8'h00) + bad, a);
      i_psr_master.stop;
      wt(10);
   end
   endtask
   task rdf(input [7:0] c);
      integer k;
   begin
      build(c);
      i_psr_master.start;
      i_psr_master.wr({addr, 1'b1}, a);
      check({7'h0, a}, 8'h00);
      for (k = 0; k < n; k = k + 1)
      begin
         i_psr_master.rd(k == n - 1, b8);
         check(b8, f[k]);
      end
      i_psr_master.stop;
      wt(10);
   end
   endtask

   initial
   begin
      repeat (100000) @(posedge clk_i);
      mismatches = mismatches + 1;
      $display("ERROR %0t: run timed out", $time);
      report_and_stop;
   end
   initial
   begin
      {rst_b_i, ga1_n, ga0_n, inh_n, en_n, fault, ot, nrec} = 8'h78;
      sexp = 8'h00;
      wt(5);
      rst_b_i = 1'b1;
      wt(10);
      req(8'h55, 8'h00, 1'b0, 8'h00);
      rdf(8'h55);
      $display("test 1 done");
      req(8'h55, 8'h18, 1'b1, 8'h00);
      sexp = 8'h18;
      rdf(8'h55);
      en_n = 1'b1;
      wt(20);
      check({7'h0, rails_on}, 8'h01);
      en_n = 1'b0;
      req(8'h55, 8'h10, 1'b1, 8'h00);
      wt(20);
      check({7'h0, rails_on}, 8'h00);
      req(8'h55, 8'h00, 1'b1, 8'h01);
      check(status, 8'h12);
      $display("test 2 done");
      req(8'h55, 8'h60, 1'b1, 8'h00);
      check(status, 8'h62);
      ot = 1'b1;
      wt(5);
      check(status, 8'h42);
      ot = 1'b0;
      fault = 1'b1;
      wt(5);
      check(status, 8'h02);
      fault = 1'b0;
      $display("test 3 done");
      req(8'h55, 8'h80, 1'b1, 8'h00);
      req(8'h55, 8'h80, 1'b1, 8'h00);
      req(8'h92, 8'h00, 1'b0, 8'h00);
      req(8'h55, 8'h80, 1'b1, 8'h00);
      check(status, 8'h02);
      req(8'h55, 8'h80, 1'b1, 8'h00);
      check(status, 8'h02);
      req(8'h55, 8'h80, 1'b1, 8'h00);
      sexp = 8'h80;
      rdf(8'h55);
      nrec = 1'b1;
      wt(20);
      check({7'h0, rails_on}, 8'h01);
      nrec = 1'b0;
      req(8'h55, 8'h00, 1'b1, 8'h00);
      sexp = 8'h00;
      nrec = 1'b1;
      wt(20);
      check({7'h0, rails_on}, 8'h00);
      nrec = 1'b0;
      $display("test 4 done");
      for (i = 0; i < 7; i = i + 1)
      begin
         req(CMDS[55 - 8 * i -: 8], 8'h00, 1'b0, 8'h00);
         rdf(CMDS[55 - 8 * i -: 8]);
      end
      $display("test 5 done");
      ga0_n = 1'b0;
      wt(10);
      i_psr_master.start;
      i_psr_master.wr(8'h40, a);
      check({7'h0, a}, 8'h01);
      i_psr_master.stop;
      req(8'h45, 8'h00, 1'b0, 8'h00);
      rdf(8'h45);
      $display("test 6 done");
      report_and_stop;
   end
endmodule // psr_responder_tb
